// File: hdl/t1dl_pkg.sv
`default_nettype none
package t1dl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CRC_HI = 8'h25;
  localparam logic [7:0] IDX_CRC_LO = 8'h26;
  localparam logic [7:0] IDX_FEC = 8'h27;
  localparam logic [7:0] IDX_RX_BYTE = 8'h28;
  localparam logic [7:0] IDX_MATCH_A = 8'h29;
  localparam logic [7:0] IDX_MATCH_B = 8'h2A;
  localparam logic [7:0] IDX_TX_BYTE = 8'h7E;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_MASK = 8'h42;
  // Control bits
  localparam int CTL_FFS = 0;
  localparam int CTL_DESTUFF = 1;
  localparam int CTL_STUFF = 2;
  localparam int CTL_FSERR = 3;
  localparam int CTL_SIGF = 4;
  // Status and mask bits
  localparam int ST_ABORT = 1;
  localparam int ST_MATCH = 2;
  localparam int ST_TXE = 3;
  localparam int ST_RXF = 4;
  localparam int ST_SEC = 5;
  localparam logic [7:0] ST_IMPL = 8'h3E;
  // Counter limits and run lengths
  localparam logic [15:0] CRC_MAX = 16'hFFFF;
  localparam logic [7:0] FEC_MAX = 8'hFF;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] RUN_CAP = 3'h7;
  localparam logic [3:0] DESTUFF_RUN = 4'h5;
  localparam logic [3:0] ABORT_RUN = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int LINE_RATE_HZ = 1544000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Line-side inputs, sampled together
  typedef struct packed {
    logic clk;
    logic data;
    logic fe_slot;
    logic ft_slot;
    logic fs_slot;
    logic fexp;
    logic dl_slot;
    logic sig_slot;
    logic crc_err;
    logic los;
    logic tx_clk;
    logic tx_slot;
  } t1dl_link_t;

  // Whole state of the block
  typedef struct packed {
    t1dl_link_t s1;
    t1dl_link_t s2;
    logic rclk_prev;
    logic tclk_prev;
    logic [4:0] control;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] match_a;
    logic [7:0] match_b;
    logic [7:0] tx_hold;
    logic [15:0] crc_live;
    logic [7:0] fec_live;
    logic [15:0] crc_rep;
    logic [7:0] fec_rep;
    logic [20:0] sec_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [3:0] rx_ones;
    logic [7:0] rx_byte;
    logic rx_ser;
    logic [7:0] tx_sh;
    logic [2:0] tx_idx;
    logic [2:0] tx_ones;
    logic tx_bit;
    logic aw_ok;
    logic [7:0] aw_idx;
    logic w_ok;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic irq_n;
  } t1dl_state_t;
endpackage
`default_nettype wire

// File: hdl/t1dl_core.sv
// What this block does
// R1 - Count CRC6 word errors, 16 bits, extended mode
// R2 - CRC6 counter stops at 65535
// R3 - Loss of sync freezes both error counters
// R4 - Extended mode: count each framing bit error
// R5 - Superframe mode: count Ft bit errors
// R6 - Fs error enable adds Fs bit errors
// R7 - Framing error counter stops at 255
// R8 - Shift data-link bits in, first bit LSB
// R9 - Full byte sets full flag, masked interrupt
// R10 - Host reads byte within 2 ms
// R11 - Byte equal to a match sets flag
// R12 - Destuffer deletes zero after exactly five ones
// R13 - Zero after six or more ones stays
// R14 - Host should keep destuffer enabled
// R15 - Send written byte LSB first in slots
// R16 - Eight bits sent sets empty flag, interrupt
// R17 - Host rewrites byte within 2 or 1.5 ms
// R18 - Unrewritten byte is sent again
// R19 - Stuffer inserts zero after five ones
// R20 - Signaling force drives robbed bits to one
// R21 - Counters reported on each one-second boundary
// R22 - Eight ones in data link set abort
// R23 - Stuff run spans bytes, zero delays bits
`default_nettype none
module t1dl_core #(
  parameter int unsigned SEC_BITS = t1dl_pkg::LINE_RATE_HZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line side, asynchronous to mclk
  input wire t1dl_pkg::t1dl_link_t link_in,
  // Line side outputs
  output logic rx_serial_out,
  output logic tx_dl_bit,
  // Interrupt, active low
  output logic second_irq_n
);

  t1dl_pkg::t1dl_state_t q;
  t1dl_pkg::t1dl_state_t d;
  logic rx_edge;
  logic tx_edge;
  logic sec_wrap;
  logic dl_take;
  logic dl_drop;
  logic rx_done;
  logic [7:0] rx_new;
  logic tx_stuff;
  logic tx_send;
  logic crc_inc;
  logic fe_inc;

  // Known register index, shared by read and write decode
  function automatic logic reg_known(input logic [7:0] idx);
    unique case (idx)
      t1dl_pkg::IDX_CRC_HI, t1dl_pkg::IDX_CRC_LO, t1dl_pkg::IDX_FEC,
      t1dl_pkg::IDX_RX_BYTE, t1dl_pkg::IDX_MATCH_A, t1dl_pkg::IDX_MATCH_B,
      t1dl_pkg::IDX_TX_BYTE, t1dl_pkg::IDX_CONTROL, t1dl_pkg::IDX_STATUS,
      t1dl_pkg::IDX_MASK: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  endfunction

  // Read data for an index; unknown reads as zero
  function automatic logic [7:0] reg_read(input t1dl_pkg::t1dl_state_t s,
                                          input logic [7:0] idx);
    unique case (idx)
      t1dl_pkg::IDX_CRC_HI: reg_read = s.crc_rep[15:8];
      t1dl_pkg::IDX_CRC_LO: reg_read = s.crc_rep[7:0];
      t1dl_pkg::IDX_FEC: reg_read = s.fec_rep;
      t1dl_pkg::IDX_RX_BYTE: reg_read = s.rx_byte;
      t1dl_pkg::IDX_MATCH_A: reg_read = s.match_a;
      t1dl_pkg::IDX_MATCH_B: reg_read = s.match_b;
      t1dl_pkg::IDX_TX_BYTE: reg_read = s.tx_hold;
      t1dl_pkg::IDX_CONTROL: reg_read = {3'h0, s.control};
      t1dl_pkg::IDX_STATUS: reg_read = s.status;
      t1dl_pkg::IDX_MASK: reg_read = s.mask;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Handshake outputs straight from state
  assign s_axi_awready = ~q.aw_ok;
  assign s_axi_wready = ~q.w_ok;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign rx_serial_out = q.rx_ser;
  assign tx_dl_bit = q.tx_bit;
  assign second_irq_n = q.irq_n;

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0] sets;
    logic [7:0] clr;
    logic ffs;
    logic dbit;
    logic tbit;
    logic [15:0] crc_base;
    logic [7:0] fec_base;
    sets = 8'h00;
    clr = 8'h00;
    d = q;
    ffs = q.control[t1dl_pkg::CTL_FFS];
    dbit = q.s2.data;
    tbit = 1'b0;
    crc_base = q.crc_live;
    fec_base = q.fec_live;

    // Two-stage sync; edges seen only past the second stage
    d.s1 = link_in;
    d.s2 = q.s1;
    d.rclk_prev = q.s2.clk;
    d.tclk_prev = q.s2.tx_clk;
    rx_edge = q.s2.clk & ~q.rclk_prev;
    tx_edge = q.s2.tx_clk & ~q.tclk_prev;

    // Second boundary counted in received bit times
    sec_wrap = rx_edge && (q.sec_cnt == 21'(SEC_BITS - 1));
    crc_inc = rx_edge && ffs && q.s2.crc_err && !q.s2.los; // R1 R3
    fe_inc = rx_edge && !q.s2.los && (q.s2.data != q.s2.fexp) && // R3
             ((ffs && q.s2.fe_slot) || // R4
              (!ffs && q.s2.ft_slot) || // R5
              (!ffs && q.control[t1dl_pkg::CTL_FSERR] && q.s2.fs_slot)); // R6
    if (rx_edge) begin
      d.sec_cnt = sec_wrap ? 21'h000000 : q.sec_cnt + 21'h000001;
    end
    // Report last second, restart live counts
    if (sec_wrap) begin
      d.crc_rep = q.crc_live; // R21
      d.fec_rep = q.fec_live; // R21
      crc_base = 16'h0000;
      fec_base = 8'h00;
      sets[t1dl_pkg::ST_SEC] = 1'b1;
    end
    // Saturating counts; an error on the wrap edge opens the new second
    d.crc_live = (crc_inc && crc_base != t1dl_pkg::CRC_MAX) ? // R2
                 crc_base + 16'h0001 : crc_base; // R1
    d.fec_live = (fe_inc && fec_base != t1dl_pkg::FEC_MAX) ? // R7
                 fec_base + 8'h01 : fec_base;

    // Receive serial out with optional forcing of robbed bits
    if (rx_edge) begin
      d.rx_ser = (q.s2.sig_slot && q.control[t1dl_pkg::CTL_SIGF]) ?
                 1'b1 : q.s2.data; // R20
    end

    // Receive data link: FDL bit in extended mode, Fs bit otherwise
    dl_take = rx_edge && (ffs ? q.s2.dl_slot : q.s2.fs_slot); // R8
    dl_drop = dl_take && !dbit && q.control[t1dl_pkg::CTL_DESTUFF] &&
              (q.rx_ones == t1dl_pkg::DESTUFF_RUN); // R12 R13
    rx_new = {dbit, q.rx_sh[7:1]}; // R8
    rx_done = dl_take && !dl_drop && (q.rx_cnt == t1dl_pkg::LAST_BIT);
    if (dl_take) begin
      // Run length saturates so long runs never look like five
      if (!dbit) begin
        d.rx_ones = 4'h0;
      end else if (q.rx_ones != t1dl_pkg::ABORT_RUN) begin
        d.rx_ones = q.rx_ones + 4'h1;
      end
      if (dbit && q.rx_ones == t1dl_pkg::ABORT_RUN - 4'h1) begin
        sets[t1dl_pkg::ST_ABORT] = 1'b1; // R22
      end
      if (!dl_drop) begin
        d.rx_sh = rx_new;
        d.rx_cnt = q.rx_cnt + 3'h1;
      end
    end
    // Byte complete: publish, flag, compare
    if (rx_done) begin
      d.rx_byte = rx_new;
      sets[t1dl_pkg::ST_RXF] = 1'b1; // R9
      if (rx_new == q.match_a || rx_new == q.match_b) begin
        sets[t1dl_pkg::ST_MATCH] = 1'b1; // R11
      end
    end

    // Transmit data link; a stuffed zero holds the bit index
    tx_send = tx_edge && q.s2.tx_slot;
    tx_stuff = tx_send && q.control[t1dl_pkg::CTL_STUFF] &&
               (q.tx_ones == t1dl_pkg::STUFF_RUN); // R19
    if (tx_stuff) begin
      d.tx_bit = 1'b0; // R23
      d.tx_ones = 3'h0;
    end else if (tx_send) begin
      // Byte start reloads the holding byte, old or new
      if (q.tx_idx == 3'h0) begin
        d.tx_sh = q.tx_hold; // R18
        tbit = q.tx_hold[0]; // R15
      end else begin
        tbit = q.tx_sh[q.tx_idx]; // R15
      end
      d.tx_bit = tbit;
      // Run carried over byte boundaries
      if (!tbit) begin
        d.tx_ones = 3'h0; // R23
      end else if (q.tx_ones != t1dl_pkg::RUN_CAP) begin
        d.tx_ones = q.tx_ones + 3'h1;
      end
      d.tx_idx = q.tx_idx + 3'h1;
      if (q.tx_idx == t1dl_pkg::LAST_BIT) begin
        sets[t1dl_pkg::ST_TXE] = 1'b1; // R16
      end
    end

    // AXI write channels, taken in either order
    if (s_axi_awvalid && !q.aw_ok) begin
      d.aw_ok = 1'b1;
      d.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && !q.w_ok) begin
      d.w_ok = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    // Commit waits until the previous response is gone
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = reg_known(q.aw_idx) ? t1dl_pkg::RESP_OKAY :
                t1dl_pkg::RESP_SLVERR;
      if (q.wstrb0) begin
        unique case (q.aw_idx)
          t1dl_pkg::IDX_MATCH_A: d.match_a = q.wdata;
          t1dl_pkg::IDX_MATCH_B: d.match_b = q.wdata;
          t1dl_pkg::IDX_TX_BYTE: d.tx_hold = q.wdata;
          t1dl_pkg::IDX_CONTROL: d.control = q.wdata[4:0];
          t1dl_pkg::IDX_STATUS: clr = q.wdata;
          t1dl_pkg::IDX_MASK: d.mask = q.wdata & t1dl_pkg::ST_IMPL;
          default: d.bresp = d.bresp;
        endcase
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // AXI read: one in flight, data one cycle after address
    if (q.rvalid) begin
      if (s_axi_rready) begin
        d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      d.rvalid = 1'b1;
      d.rdata = reg_read(q, s_axi_araddr[9:2]);
      d.rresp = reg_known(s_axi_araddr[9:2]) ? t1dl_pkg::RESP_OKAY :
                t1dl_pkg::RESP_SLVERR;
    end

    // Sticky flags: write one to clear, a new event wins
    d.status = ((q.status & ~clr) | sets) & t1dl_pkg::ST_IMPL;
    // New mask acts with the flags, so a mask write never leaves a stale level
    d.irq_n = ~|(d.status & d.mask); // R9 R11 R16
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      q <= '0;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Checks on the block's own behaviour
  crc_sat_a: assert property (@(posedge mclk) disable iff (!nrst) // R2
    (q.crc_live == t1dl_pkg::CRC_MAX && !sec_wrap) |=> q.crc_live == t1dl_pkg::CRC_MAX)
    else $error("crc count left its maximum");
  fec_sat_a: assert property (@(posedge mclk) disable iff (!nrst) // R7
    (q.fec_live == t1dl_pkg::FEC_MAX && !sec_wrap) |=> q.fec_live == t1dl_pkg::FEC_MAX)
    else $error("framing count left its maximum");
  los_freeze_a: assert property (@(posedge mclk) disable iff (!nrst) // R3
    (q.s2.los && !sec_wrap) |=> $stable(q.crc_live) && $stable(q.fec_live))
    else $error("counter moved during loss of sync");
  crc_mode_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
    (!q.control[t1dl_pkg::CTL_FFS] && !sec_wrap) |=> $stable(q.crc_live))
    else $error("crc count moved outside extended mode");
  crc_count_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
    (crc_inc && !sec_wrap && q.crc_live != t1dl_pkg::CRC_MAX)
      |=> q.crc_live == $past(q.crc_live) + 16'h0001)
    else $error("crc error not counted");
  fe_ft_a: assert property (@(posedge mclk) disable iff (!nrst) // R5
    (rx_edge && !q.s2.los && !q.control[t1dl_pkg::CTL_FFS] && q.s2.ft_slot &&
     q.s2.data != q.s2.fexp && !sec_wrap && q.fec_live != t1dl_pkg::FEC_MAX)
      |=> q.fec_live == $past(q.fec_live) + 8'h01)
    else $error("Ft bit error not counted");
  report_a: assert property (@(posedge mclk) disable iff (!nrst) // R21
    sec_wrap |=> q.crc_rep == $past(q.crc_live) && q.fec_rep == $past(q.fec_live) &&
      q.status[t1dl_pkg::ST_SEC])
    else $error("second boundary did not report counts");
  rx_full_a: assert property (@(posedge mclk) disable iff (!nrst) // R9
    rx_done |=> q.status[t1dl_pkg::ST_RXF] && q.rx_byte == $past(rx_new))
    else $error("full byte not published");
  rx_match_a: assert property (@(posedge mclk) disable iff (!nrst) // R11
    (rx_done && (rx_new == q.match_a || rx_new == q.match_b))
      |=> q.status[t1dl_pkg::ST_MATCH])
    else $error("match flag missed");
  destuff_a: assert property (@(posedge mclk) disable iff (!nrst) // R12
    dl_drop |=> $stable(q.rx_cnt) && $stable(q.rx_sh))
    else $error("stuffed zero kept");
  abort_a: assert property (@(posedge mclk) disable iff (!nrst) // R22
    (dl_take && q.s2.data && q.rx_ones == t1dl_pkg::ABORT_RUN - 4'h1)
      |=> q.status[t1dl_pkg::ST_ABORT])
    else $error("abort flag missed");
  stuff_a: assert property (@(posedge mclk) disable iff (!nrst) // R19
    tx_stuff |=> !q.tx_bit && $stable(q.tx_idx))
    else $error("zero not stuffed");
  tx_empty_a: assert property (@(posedge mclk) disable iff (!nrst) // R16
    (tx_send && !tx_stuff && q.tx_idx == t1dl_pkg::LAST_BIT)
      |=> q.status[t1dl_pkg::ST_TXE] && q.tx_idx == 3'h0)
    else $error("empty flag missed");
  sig_force_a: assert property (@(posedge mclk) disable iff (!nrst) // R20
    (rx_edge && q.s2.sig_slot && q.control[t1dl_pkg::CTL_SIGF]) |=> rx_serial_out)
    else $error("robbed bit not forced");
  irq_a: assert property (@(posedge mclk) disable iff (!nrst) // R9
    (q.status[t1dl_pkg::ST_RXF] && q.mask[t1dl_pkg::ST_RXF]) |-> !second_irq_n)
    else $error("interrupt not asserted");

  // Framing error sources, destuffing, receive shifting, pass-through, transmit reload and interrupt level
  fe_esf_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
    (rx_edge && !q.s2.los && q.control[t1dl_pkg::CTL_FFS] && q.s2.fe_slot &&
     q.s2.data != q.s2.fexp && !sec_wrap && q.fec_live != t1dl_pkg::FEC_MAX)
      |=> q.fec_live == $past(q.fec_live) + 8'h01)
    else $error("extended mode framing error not counted");
  fe_fs_a: assert property (@(posedge mclk) disable iff (!nrst) // R6
    (rx_edge && !q.s2.los && !q.control[t1dl_pkg::CTL_FFS] &&
     q.control[t1dl_pkg::CTL_FSERR] && q.s2.fs_slot && q.s2.data != q.s2.fexp &&
     !sec_wrap && q.fec_live != t1dl_pkg::FEC_MAX)
      |=> q.fec_live == $past(q.fec_live) + 8'h01)
    else $error("Fs bit error not counted");
  long_run_a: assert property (@(posedge mclk) disable iff (!nrst) // R13
    (dl_take && !q.s2.data && q.rx_ones > t1dl_pkg::DESTUFF_RUN)
      |=> q.rx_cnt == $past(q.rx_cnt) + 3'h1)
    else $error("zero after a long run dropped");
  rx_shift_a: assert property (@(posedge mclk) disable iff (!nrst) // R8
    (dl_take && !dl_drop) |=> q.rx_sh[7] == $past(q.s2.data))
    else $error("data-link bit not shifted in at the top");
  tx_reload_a: assert property (@(posedge mclk) disable iff (!nrst) // R15 R18
    (tx_send && !tx_stuff && q.tx_idx == 3'h0)
      |=> q.tx_sh == $past(q.tx_hold) && q.tx_bit == $past(q.tx_hold[0]))
    else $error("byte start did not load the held byte");
  sig_pass_a: assert property (@(posedge mclk) disable iff (!nrst) // R20
    (rx_edge && !(q.s2.sig_slot && q.control[t1dl_pkg::CTL_SIGF]))
      |=> rx_serial_out == $past(q.s2.data))
    else $error("received bit not passed through");
  irq_level_a: assert property (@(posedge mclk) disable iff (!nrst) // R11 R16
    second_irq_n == !(|(q.status & q.mask)))
    else $error("interrupt level does not follow flags");
endmodule
`default_nettype wire

// File: hdl/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// File: testbench/t1dl_line_model.sv
`default_nettype none
// Framer stand-in on the line side; both line clocks stand still between bits
module t1dl_line_model (
  // Clock and observed outputs
  input wire logic mclk,
  input wire logic rx_serial_out,
  input wire logic tx_dl_bit,
  // Stream into the block
  output var t1dl_pkg::t1dl_link_t link
);
  timeunit 1ns;
  timeprecision 1ps;
  initial link = '0;
  // One rx bit, 320 ns; fields settle with clk low and hold past the rise
  task automatic rx_bit(input t1dl_pkg::t1dl_link_t x, output logic s);
    x.clk = 1'b0;
    x.tx_clk = link.tx_clk;
    x.tx_slot = link.tx_slot;
    link <= x;
    repeat (4) @(posedge mclk);
    #1;
    link.clk <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    s = rx_serial_out; // Output is sampled late, sync delay covered
  endtask
  // One tx data-link slot, same timing as rx
  task automatic tx_bit(output logic s);
    link.tx_clk <= 1'b0;
    link.tx_slot <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    link.tx_clk <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    s = tx_dl_bit;
  endtask
endmodule
`default_nettype wire

// File: testbench/t1_error_count_and_datalink_tb_top.sv
`default_nettype none
module t1_error_count_and_datalink_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEC = 300;
  localparam logic [31:0] PAT = 32'h003FDFBE;
  logic mclk = 0;
  logic nrst = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, r_d, d;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_serial_out, tx_dl_bit, second_irq_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, r_s, b_s, rs;
  logic aw_hs, w_hs, ar_hs, b_hs, r_hs, b;
  logic [7:0] ctl = '0, sh = '0, m, g;
  logic [7:0] idx_t [10] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h7E, 8'h40, 8'h41, 8'h42};
  logic [7:0] cfg [4] = '{8'h11, 8'h00, 8'h1A, 8'h01};
  int errors = 0, n_compared = 0, cyc = 0, nrx = 0, ones = 0, kept = 0, crc, fec, run;
  t1dl_pkg::t1dl_link_t link_in, f;

  t1dl_core #(.SEC_BITS(SEC)) uut (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_in, .rx_serial_out, .tx_dl_bit, .second_irq_n);
  t1dl_line_model line (.mclk, .rx_serial_out, .tx_dl_bit, .link(link_in));

  // 25 MHz clock
  always #20 mclk = ~mclk;
  // Handshakes latched at the edge, so tasks never race the design
  always @(posedge mclk) begin
    aw_hs <= s_axi_awvalid & s_axi_awready;
    w_hs <= s_axi_wvalid & s_axi_wready;
    ar_hs <= s_axi_arvalid & s_axi_arready;
    b_hs <= s_axi_bvalid & s_axi_bready;
    r_hs <= s_axi_rvalid & s_axi_rready;
    b_s <= s_axi_bresp;
    r_d <= s_axi_rdata;
    r_s <= s_axi_rresp;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      complete_run;
    end
  end

  // Verdict and end of run
  task automatic complete_run;
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // Bus master: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      tick;
      if (aw_hs) s_axi_awvalid <= 0;
      if (w_hs) s_axi_wvalid <= 0;
    end while (!b_hs);
    s_axi_bready <= 0;
    chk("bresp", t1dl_pkg::RESP_OKAY, b_s);
    tick;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] o, output logic [1:0] p);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      tick;
      if (ar_hs) s_axi_arvalid <= 0;
    end while (!r_hs);
    s_axi_rready <= 0;
    o = r_d;
    p = r_s;
    tick;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] o;
    logic [1:0] p;
    rd(idx, o, p);
    chk(what, exp, o);
    chk("rresp", t1dl_pkg::RESP_OKAY, p);
  endtask
  // One rx bit through the line, mirrored by a destuffing byte collector
  task automatic rxb(input t1dl_pkg::t1dl_link_t x);
    logic s;
    line.rx_bit(x, s);
    nrx++;
    chk("rx_serial_out", (x.sig_slot && ctl[4]) ? 1'b1 : x.data, s);
    if (ctl[0] ? x.dl_slot : x.fs_slot) begin
      if (x.data || ones != 5 || !ctl[1]) begin
        sh = {x.data, sh[7:1]};
        kept++;
        if (kept == 8) begin
          kept = 0;
          rdc(t1dl_pkg::IDX_RX_BYTE, {24'h0, sh}, "rx byte");
        end
      end
      ones = x.data ? ones + 1 : 0;
    end
  endtask

  // Main sequence
  initial begin
    void'($urandom(78));
    repeat (5) @(posedge mclk);
    nrst <= 1;
    tick;
    foreach (idx_t[i]) rdc(idx_t[i], 0, "reset value");
    rd(8'h10, d, rs);
    chk("unmapped data", 0, d);
    chk("unmapped resp", t1dl_pkg::RESP_SLVERR, rs);
    m = 8'($urandom);
    g = ~m;
    wr(t1dl_pkg::IDX_MATCH_A, m);
    wr(t1dl_pkg::IDX_MATCH_B, g);
    rdc(t1dl_pkg::IDX_MATCH_A, m, "match a");
    rdc(t1dl_pkg::IDX_MATCH_B, g, "match b");
    wr(t1dl_pkg::IDX_CRC_HI, 8'hAB);
    rdc(t1dl_pkg::IDX_CRC_HI, 0, "read-only write");
    ctl = 8'h01;
    wr(t1dl_pkg::IDX_CONTROL, ctl);
    wr(t1dl_pkg::IDX_MASK, 8'h10);
    // First byte raises irq via full, second via a match alone
    for (int k = 0; k < 2; k++) begin
      g = k ? ~m : m;
      for (int i = 0; i < 8; i++) begin
        f = '0;
        f.dl_slot = 1;
        f.data = g[i];
        f.sig_slot = 1'($urandom);
        rxb(f);
      end
      rd(t1dl_pkg::IDX_STATUS, d, rs);
      chk("full and match", 32'h14, d & 32'h14);
      chk("irq low", 0, second_irq_n);
      wr(t1dl_pkg::IDX_STATUS, 8'h3E);
      chk("irq cleared", 1, second_irq_n);
      wr(t1dl_pkg::IDX_MASK, 8'h04);
    end
    ctl = 8'h03;
    wr(t1dl_pkg::IDX_CONTROL, ctl);
    for (int i = 0; i < 32; i++) begin
      f = '0;
      f.dl_slot = 1;
      f.data = PAT[i];
      rxb(f);
    end
    rd(t1dl_pkg::IDX_STATUS, d, rs);
    chk("abort", 32'h2, d & 32'h2);
    // Top bit clear so no ones run leaks into the stuffing check
    m = 8'($urandom) & 8'h7F;
    wr(t1dl_pkg::IDX_TX_BYTE, m);
    rdc(t1dl_pkg::IDX_TX_BYTE, m, "tx byte reg");
    repeat (2) begin
      for (int i = 0; i < 8; i++) begin
        line.tx_bit(b);
        g[i] = b;
      end
      chk("tx byte", m, g);
    end
    rd(t1dl_pkg::IDX_STATUS, d, rs);
    chk("tx empty", 32'h8, d & 32'h8);
    ctl = 8'h05;
    wr(t1dl_pkg::IDX_CONTROL, ctl);
    wr(t1dl_pkg::IDX_TX_BYTE, 8'hFF);
    run = 0;
    for (int i = 0; i < 20; i++) begin
      line.tx_bit(b);
      chk("stuffed stream", run != 5, b);
      run = (run == 5) ? 0 : run + 1;
    end
    // One aligned second per mode; no errors near the wrap edges
    for (int c = 0; c < 4; c++) begin
      ctl = cfg[c];
      wr(t1dl_pkg::IDX_CONTROL, ctl);
      while (nrx % SEC != 0) rxb('0);
      wr(t1dl_pkg::IDX_STATUS, 8'h20);
      crc = 0;
      fec = 0;
      for (int e = 1; e <= SEC; e++) begin
        f = 12'($urandom);
        f.los = (c == 3);
        if (c == 0) begin
          f.fe_slot = 1;
          f.crc_err = 1;
          f.fexp = ~f.data;
        end
        if (c == 3) begin
          f.dl_slot = 0;
          f.fs_slot = 0;
        end
        if (e < 3 || e > SEC - 2) begin
          f.crc_err = 0;
          f.fexp = f.data;
        end
        if (!f.los && ctl[0] && f.crc_err && crc < 65535) crc++;
        if (!f.los && f.data != f.fexp && fec < 255
            && (ctl[0] ? f.fe_slot : (f.ft_slot || (f.fs_slot && ctl[3])))) fec++;
        rxb(f);
      end
      rd(t1dl_pkg::IDX_STATUS, d, rs);
      chk("second flag", 32'h20, d & 32'h20);
      rdc(t1dl_pkg::IDX_CRC_HI, crc >> 8, "crc high");
      rdc(t1dl_pkg::IDX_CRC_LO, crc & 255, "crc low");
      rdc(t1dl_pkg::IDX_FEC, fec, "framing errors");
    end
    complete_run;
  end
endmodule
`default_nettype wire
